/* design/fff_pkg.sv */
// constants and types shared by the fifo flag logic and its output buffer
package fff_pkg;
   // word and offset register geometry
   localparam int DATA_W = 9;
   localparam int OFF_REG_W = 8;
   localparam int OFF_W = 2 * OFF_REG_W;
   // the two supported storage depths
   localparam int DEPTH_16K = 16384;
   localparam int DEPTH_32K = 32768;
   // width wide enough to compare counts and offsets of either depth
   localparam int CMP_W = 17;
   // default almost-empty and almost-full offsets after reset
   localparam logic [OFF_W-1:0] OFFSET_DEFAULT = 16'h0007;
   localparam logic [OFF_REG_W-1:0] OFF_LSB_DEFAULT = 8'h07;
   localparam logic [OFF_REG_W-1:0] OFF_MSB_DEFAULT = 8'h00;
   // two-entry output buffer
   localparam int BUF_DEPTH = 2;
   // rotating selection of the four offset registers
   typedef enum logic [3:0] {
      SEL_EMPTY_LSB = 4'h1,
      SEL_EMPTY_MSB = 4'h2,
      SEL_FULL_LSB = 4'h4,
      SEL_FULL_MSB = 4'h8
   } fff_sel_t;
   // next register in the rotation
   function automatic fff_sel_t fff_sel_next(input fff_sel_t s);
      fff_sel_t r;
      r = SEL_EMPTY_LSB;
      unique case (s)
         SEL_EMPTY_LSB: r = SEL_EMPTY_MSB;
         SEL_EMPTY_MSB: r = SEL_FULL_LSB;
         SEL_FULL_LSB: r = SEL_FULL_MSB;
         SEL_FULL_MSB: r = SEL_EMPTY_LSB;
         default: r = SEL_EMPTY_LSB;
      endcase
      return r;
   endfunction : fff_sel_next
endpackage : fff_pkg

/* design/fff_out_buf.sv */
// two-entry output buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fff_out_buf (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [fff_pkg::DATA_W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [fff_pkg::DATA_W-1:0] out_data_out
);
   import fff_pkg::*;

   logic head_valid_r;
   logic tail_valid_r;
   logic [DATA_W-1:0] head_r;
   logic [DATA_W-1:0] tail_r;
   logic push;
   logic pop;

   // ready only depends on the spare slot, so no path runs through
   assign in_ready_out = !tail_valid_r;
   assign out_valid_out = head_valid_r;
   assign out_data_out = head_r;
   assign push = in_valid_in && !tail_valid_r;
   assign pop = head_valid_r && out_ready_in;

   // occupancy of the two slots
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         head_valid_r <= 1'b0;
         tail_valid_r <= 1'b0;
      end else begin
         head_valid_r <= push || tail_valid_r || (head_valid_r && !pop);
         tail_valid_r <= (tail_valid_r && !pop) ||
                         (push && head_valid_r && !pop);
      end
   end

   // head keeps the last word after draining, like the output register
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         head_r <= '0;
         tail_r <= '0;
      end else begin
         if (pop && tail_valid_r) begin
            head_r <= tail_r;
         end else if (push && (!head_valid_r || pop)) begin
            head_r <= in_data_in;
         end
         if (push && head_valid_r && !pop) begin
            tail_r <= in_data_in;
         end
      end
   end
endmodule : fff_out_buf
`default_nettype wire

/* design/fff_flag_logic.sv */
// synchronous nine-bit fifo storage with full, empty and programmable flags
`timescale 1ns/1ps
`default_nettype none
module fff_flag_logic #(
   parameter int DEPTH = fff_pkg::DEPTH_16K
) (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic [fff_pkg::DATA_W-1:0] write_data_in,
   input wire logic write_enable_primary_n_in,
   input wire logic write_enable_or_load_in,
   input wire logic read_enable_primary_n_in,
   input wire logic read_enable_secondary_n_in,
   output logic [fff_pkg::DATA_W-1:0] read_data_out,
   output logic read_valid_out,
   input wire logic read_ready_in,
   output logic load_mode_out,
   output logic full_flag_n_out,
   output logic empty_flag_n_out,
   output logic almost_empty_flag_n_out,
   output logic almost_full_flag_n_out
);
   import fff_pkg::*;

   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [CMP_W-1:0] DEPTH_C = CMP_W'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   logic [DATA_W-1:0] storage [0:DEPTH-1];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [CMP_W-1:0] count_r;
   logic [CMP_W-1:0] count_nxt;
   logic load_mode_r;
   fff_sel_t sel_r;
   logic [OFF_REG_W-1:0] off_regs_r [0:3];
   logic [OFF_W-1:0] empty_offset;
   logic [OFF_W-1:0] full_offset;
   logic wr_attempt;
   logic rd_attempt;
   logic wr_fire;
   logic rd_fire;
   logic ofs_write;
   logic ofs_read;
   logic ofs_read_fire;
   logic buf_in_valid;
   logic buf_in_ready;
   logic [DATA_W-1:0] buf_in_data;
   logic [OFF_REG_W-1:0] sel_value;
   logic [1:0] sel_idx;
   logic full_flag_n_r;
   logic empty_flag_n_r;
   logic almost_empty_flag_n_r;
   logic almost_full_flag_n_r;

   // load pin is a second write enable unless it was low at reset
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         load_mode_r <= !write_enable_or_load_in;
      end
   end
   assign load_mode_out = load_mode_r;

   // decode of the enable pins in each configuration
   always_comb begin
      wr_attempt = 1'b0;
      ofs_write = 1'b0;
      ofs_read = 1'b0;
      rd_attempt = !read_enable_primary_n_in && !read_enable_secondary_n_in;
      if (load_mode_r) begin
         ofs_write = !write_enable_primary_n_in && !write_enable_or_load_in;
         wr_attempt = !write_enable_primary_n_in && write_enable_or_load_in;
         ofs_read = !write_enable_or_load_in && rd_attempt;
         if (!write_enable_or_load_in) begin
            rd_attempt = 1'b0; // offset readback replaces a fifo read
         end
      end else begin
         wr_attempt = !write_enable_primary_n_in && write_enable_or_load_in;
      end
   end

   // overflow and underflow guards use the registered flags
   assign wr_fire = wr_attempt && full_flag_n_r;
   assign rd_fire = rd_attempt && empty_flag_n_r &&
                    buf_in_ready;
   // a write to the offsets takes the slot, reads then wait
   assign ofs_read_fire = ofs_read && !ofs_write && buf_in_ready;

   // index of the currently selected offset register
   always_comb begin
      sel_idx = 2'h0;
      unique case (sel_r)
         SEL_EMPTY_LSB: sel_idx = 2'h0;
         SEL_EMPTY_MSB: sel_idx = 2'h1;
         SEL_FULL_LSB: sel_idx = 2'h2;
         SEL_FULL_MSB: sel_idx = 2'h3;
         default: sel_idx = 2'h0;
      endcase
   end
   assign sel_value = off_regs_r[sel_idx];

   // writes and readbacks share one rotating pointer
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         sel_r <= SEL_EMPTY_LSB;
      end else if (ofs_write || ofs_read_fire) begin
         sel_r <= fff_sel_next(sel_r);
      end
   end

   // offset registers, both offsets start at the default
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         off_regs_r[0] <= OFF_LSB_DEFAULT;
         off_regs_r[1] <= OFF_MSB_DEFAULT;
         off_regs_r[2] <= OFF_LSB_DEFAULT;
         off_regs_r[3] <= OFF_MSB_DEFAULT;
      end else if (ofs_write) begin
         off_regs_r[sel_idx] <= write_data_in[OFF_REG_W-1:0];
      end
   end
   assign empty_offset = {off_regs_r[1], off_regs_r[0]};
   assign full_offset = {off_regs_r[3], off_regs_r[2]};

   // storage array, written only when a word really goes in
   always_ff @(posedge clock_in) begin
      if (wr_fire) begin
         storage[wr_ptr_r] <= write_data_in;
      end
   end

   // pointers wrap at the configured depth
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (wr_fire) begin
            wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
         end
         if (rd_fire) begin
            rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // unread word count; single clock so one counter serves all four flags
   always_comb begin
      count_nxt = count_r;
      if (wr_fire && !rd_fire) begin
         count_nxt = count_r + 1'b1;
      end else if (rd_fire && !wr_fire) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   // flags are registered from the next count, so they track count_r
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         full_flag_n_r <= 1'b1;
         empty_flag_n_r <= 1'b0;
         almost_empty_flag_n_r <= 1'b0;
         almost_full_flag_n_r <= 1'b1;
      end else begin
         full_flag_n_r <= (count_nxt != DEPTH_C);
         empty_flag_n_r <= (count_nxt != '0);
         almost_empty_flag_n_r <=
            (count_nxt > CMP_W'(empty_offset));
         almost_full_flag_n_r <=
            ((DEPTH_C - count_nxt) > CMP_W'(full_offset));
      end
   end

   // flag pins come straight from flip-flops
   assign full_flag_n_out = full_flag_n_r;
   assign empty_flag_n_out = empty_flag_n_r;
   assign almost_empty_flag_n_out = almost_empty_flag_n_r;
   assign almost_full_flag_n_out = almost_full_flag_n_r;

   // the buffer stalls reads instead of dropping words on a slow receiver
   assign buf_in_valid = rd_fire || ofs_read_fire;
   assign buf_in_data = rd_fire ? storage[rd_ptr_r] :
                        {1'b0, sel_value};

   fff_out_buf u_fff_out_buf (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .in_valid_in(buf_in_valid),
      .in_ready_out(buf_in_ready),
      .in_data_in(buf_in_data),
      .out_valid_out(read_valid_out),
      .out_ready_in(read_ready_in),
      .out_data_out(read_data_out)
   );

   // checks on the flag, offset register and count behaviour
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);

   sequence s_blocked_write;
      wr_attempt && !full_flag_n_out;
   endsequence

   sequence s_blocked_read;
      rd_attempt && !empty_flag_n_out;
   endsequence

   sequence s_offset_read;
      ofs_read_fire;
   endsequence

   property p_full_at_depth;
      (count_r == DEPTH_C) |-> !full_flag_n_out;
   endproperty
   a_full_at_depth: assert property (p_full_at_depth)
      else $error("full flag high with fifo full");

   property p_no_write_when_full;
      s_blocked_write |=> (wr_ptr_r == $past(wr_ptr_r)) &&
                          (count_r <= $past(count_r));
   endproperty
   a_no_write_when_full: assert property (p_no_write_when_full)
      else $error("write taken while full");

   property p_full_follows_count;
      $changed(full_flag_n_out) |-> $past(wr_fire) || $past(rd_fire);
   endproperty
   a_full_follows_count: assert property (p_full_follows_count)
      else $error("full flag moved without a transfer");

   property p_empty_at_zero;
      (count_r == '0) |-> !empty_flag_n_out;
   endproperty
   a_empty_at_zero: assert property (p_empty_at_zero)
      else $error("empty flag high with no data");

   property p_no_read_when_empty;
      s_blocked_read |=> (rd_ptr_r == $past(rd_ptr_r)) &&
                         !$rose(read_valid_out);
   endproperty
   a_no_read_when_empty: assert property (p_no_read_when_empty)
      else $error("read taken while empty");

   property p_empty_rises_after_data;
      $rose(empty_flag_n_out) |-> $past(wr_fire) && (count_r == 1);
   endproperty
   a_empty_rises_after_data: assert property (p_empty_rises_after_data)
      else $error("empty flag rose without a write");

   property p_offset_rotation;
      // the readback word must reach the buffer while the pointer moves on
      s_offset_read |=> (sel_r == fff_sel_next($past(sel_r))) &&
                        read_valid_out;
   endproperty
   a_offset_rotation: assert property (p_offset_rotation)
      else $error("offset readback did not rotate");

   property p_offset_default;
      $fell(reset_in) |-> (empty_offset == OFFSET_DEFAULT) &&
                          (full_offset == OFFSET_DEFAULT);
   endproperty
   a_offset_default: assert property (p_offset_default)
      else $error("offsets not at default after reset");

   property p_almost_empty_level;
      almost_empty_flag_n_out == (count_r > CMP_W'(empty_offset)) ||
      $past(ofs_write);
   endproperty
   a_almost_empty_level: assert property (p_almost_empty_level)
      else $error("almost-empty flag wrong for count");

   property p_almost_full_level;
      almost_full_flag_n_out ==
         ((DEPTH_C - count_r) > CMP_W'(full_offset)) || $past(ofs_write);
   endproperty
   a_almost_full_level: assert property (p_almost_full_level)
      else $error("almost-full flag wrong for free space");

   property p_count_bounded;
      count_r <= DEPTH_C;
   endproperty
   a_count_bounded: assert property (p_count_bounded)
      else $error("count beyond depth");
endmodule : fff_flag_logic
`default_nettype wire

/* bench/fff_host_model.sv */
// host side model: takes words from the read port, promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module fff_host_model (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic read_valid_in,
   input wire logic [fff_pkg::DATA_W-1:0] read_data_in,
   input wire logic stall_in,
   input wire logic slow_in,
   output logic read_ready_out
);
   import fff_pkg::*;
   logic tick_r;
   logic [DATA_W-1:0] got[$];
   // slow mode offers ready every other cycle so the buffer backs up
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= ~tick_r;
      end
   end
   assign read_ready_out = !stall_in && (!slow_in || tick_r);
   // a word is taken at the edge where valid and ready are both high
   always @(posedge clock_in) begin
      if (!reset_in && read_valid_in && read_ready_out) begin
         got.push_back(read_data_in);
      end
   end
endmodule : fff_host_model
`default_nettype wire

/* bench/fff_flag_logic_tb.sv */
// self-checking bench for the fifo flag logic
`timescale 1ns/1ps
`default_nettype none
module fff_flag_logic_tb;
   import fff_pkg::*;
   typedef logic [DATA_W-1:0] fff_word_q_t[$];
   localparam int DEPTH = DEPTH_16K;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic [DATA_W-1:0] wd = '0;
   logic wr_en_n = 1'b1;
   logic wr_en_or_load = 1'b1;
   logic rd_en_a_n = 1'b1;
   logic rd_en_b_n = 1'b1;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic ready;
   logic [DATA_W-1:0] rd;
   logic rv, load, full_n, empty_n, aempty_n, afull_n;
   int n_fail = 0;
   int n_compared = 0;
   int base = 0;
   // free-running clock, 40 ns period
   always #20 clock_in = ~clock_in;
   fff_flag_logic #(.DEPTH(DEPTH)) u_fff_flag_logic (
      .clock_in(clock_in), .reset_in(reset_in), .write_data_in(wd),
      .write_enable_primary_n_in(wr_en_n),
      .write_enable_or_load_in(wr_en_or_load),
      .read_enable_primary_n_in(rd_en_a_n),
      .read_enable_secondary_n_in(rd_en_b_n),
      .read_data_out(rd), .read_valid_out(rv), .read_ready_in(ready),
      .load_mode_out(load), .full_flag_n_out(full_n),
      .empty_flag_n_out(empty_n),
      .almost_empty_flag_n_out(aempty_n), .almost_full_flag_n_out(afull_n));
   fff_host_model u_fff_host_model (
      .clock_in(clock_in), .reset_in(reset_in), .read_valid_in(rv),
      .read_data_in(rd), .stall_in(stall), .slow_in(slow),
      .read_ready_out(ready));
   // inputs always move 1 ns after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : step
   task automatic chk(input logic [DATA_W-1:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
            exp);
      end
   endtask : chk
   // flags packed as empty, full, almost empty, almost full
   task automatic flg(input logic [3:0] exp, input string what);
      chk({5'h00, empty_n, full_n, aempty_n, afull_n}, {5'h00, exp}, what);
   endtask : flg
   // the load pin keeps its reset level; the caller moves it afterwards
   task automatic rst(input logic load_lvl);
      reset_in = 1'b1;
      wr_en_or_load = load_lvl;
      step(16);
      reset_in = 1'b0;
      base = u_fff_host_model.got.size();
   endtask : rst
   // enables stay low across the run so writes go back to back; the idle
   // edge at the end keeps two runs from moving the enable in one step
   task automatic fill(input int n, input int first);
      wr_en_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         wd = DATA_W'(first + i);
         step(1);
      end
      wr_en_n = 1'b1;
      step(1);
   endtask : fill
   task automatic rd1;
      rd_en_a_n = 1'b0;
      rd_en_b_n = 1'b0;
      step(1);
      rd_en_a_n = 1'b1;
      rd_en_b_n = 1'b1;
      step(3);
   endtask : rd1
   // reads stay requested until both the fifo and the buffer are dry
   task automatic drain;
      int k;
      k = 0;
      rd_en_a_n = 1'b0;
      rd_en_b_n = 1'b0;
      while (!(empty_n === 1'b0 && rv === 1'b0) && k < 3 * DEPTH) begin
         step(1);
         k++;
      end
      step(2);
      rd_en_a_n = 1'b1;
      rd_en_b_n = 1'b1;
   endtask : drain
   function automatic fff_word_q_t seq(input int n, input int first);
      fff_word_q_t q;
      for (int i = 0; i < n; i++) q.push_back(DATA_W'(first + i));
      return q;
   endfunction : seq
   // compares the words taken by the host since the last mark
   task automatic cmp_log(input fff_word_q_t e);
      // full-width count: a nine-bit compare would hide whole wraps
      n_compared++;
      if (u_fff_host_model.got.size() - base != e.size()) begin
         n_fail++;
         $display("CHECK FAILED at %0t: word count", $time);
      end
      for (int i = 0; i < e.size(); i++) begin
         chk(u_fff_host_model.got[base + i], e[i], "word");
      end
      base = u_fff_host_model.got.size();
   endtask : cmp_log
   task automatic end_of_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // hang guard: the tests need about 50k cycles, mostly the slow drain
   initial begin
      repeat (80000) @(posedge clock_in);
      n_fail++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_of_test();
   end
   initial begin
      rst(1'b1);
      chk({8'h00, load}, 9'h000, "load mode");
      flg(4'b0101, "reset flags");
      rd_en_a_n = 1'b0;
      rd_en_b_n = 1'b0;
      step(4);
      chk({8'h00, rv}, 9'h000, "read while empty");
      rd_en_a_n = 1'b1;
      rd_en_b_n = 1'b1;
      fill(7, 9'h010);
      flg(4'b1101, "seven words");
      fill(1, 9'h017);
      flg(4'b1111, "eight words");
      // receiver stalls: two words wait in the buffer, the rest stay stored
      stall = 1'b1;
      rd_en_a_n = 1'b0;
      rd_en_b_n = 1'b0;
      step(6);
      chk(rd, 9'h010, "stalled head");
      chk({8'h00, rv & empty_n}, 9'h001, "stall holds");
      stall = 1'b0;
      drain();
      cmp_log(seq(8, 9'h010));
      flg(4'b0101, "drained");
      // fill to the brim, then overrun
      fill(DEPTH - 8, 0);
      flg(4'b1111, "free eight");
      fill(1, DEPTH - 8);
      flg(4'b1110, "free seven");
      fill(6, DEPTH - 7);
      flg(4'b1110, "one free");
      fill(1, DEPTH - 1);
      flg(4'b1010, "full");
      fill(3, 9'h155);
      flg(4'b1010, "overrun");
      rd1();
      flg(4'b1110, "one read");
      slow = 1'b1;
      drain();
      slow = 1'b0;
      cmp_log(seq(DEPTH, 0));
      flg(4'b0101, "empty again");
      // load mode: defaults read back, then program and rotate
      rst(1'b0);
      chk({8'h00, load}, 9'h001, "load mode");
      repeat (4) rd1();
      cmp_log('{9'h007, 9'h000, 9'h007, 9'h000});
      wr_en_n = 1'b0;
      for (int i = 0; i < 4; i++) begin
         wd = (i == 0) ? 9'h002 : (i == 2) ? 9'h003 : 9'h000;
         step(1);
      end
      wr_en_n = 1'b1;
      repeat (4) rd1();
      cmp_log('{9'h002, 9'h000, 9'h003, 9'h000});
      wr_en_or_load = 1'b1;
      fill(2, 9'h040);
      flg(4'b1101, "two words, n two");
      fill(1, 9'h042);
      flg(4'b1111, "three words");
      end_of_test();
   end
endmodule : fff_flag_logic_tb
`default_nettype wire
